// ---- fpu_exc_signal.sv ----
// Floating-point exception recording, trap selection and error line
`default_nettype none
module fpu_exc_signal
    import fpu_exc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic control_register_zero_native, // Native error select copy
    input wire logic task_switched_flag,
    input wire logic x87_exc_valid,                 // Scalar op finished with exceptions
    input wire logic [EXC_W-1:0] x87_exc_flags,
    input wire logic [EXC_W-1:0] x87_exc_mask,
    input wire logic x87_status_clear,              // Software clears/reloads status
    input wire logic insn_issue,                    // Next instruction about to execute
    input wire logic insn_is_fp,
    input wire logic insn_is_wait,
    input wire logic insn_is_nowait,
    input wire logic insn_is_nowait_save,
    input wire logic simd_valid,
    input wire logic [LANES*EXC_W-1:0] simd_lane_flags,
    input wire logic [EXC_W-1:0] simd_mask,
    input wire logic simd_flag_clear,
    output logic float_error_output_n,
    output logic scalar_pending,
    output logic trap_valid,
    output logic [7:0] trap_vector,
    output logic insn_proceed,
    output logic simd_default_result,
    output logic [EXC_W-1:0] simd_sticky_flags
);
    err_state_t state_reg, state_next;
    logic [3:0] pulse_cnt_reg, pulse_cnt_next;
    logic [EXC_W-1:0] simd_or;
    logic [EXC_W-1:0] sticky_next;

    // Packed lanes folded into one flag set, lane identity lost
    genvar g;
    generate
        for (g = 0; g < EXC_W; g++) begin : g_or
            logic [LANES-1:0] col;
            for (genvar l = 0; l < LANES; l++) begin : g_lane
                assign col[l] = simd_lane_flags[l*EXC_W+g];
            end
            assign simd_or[g] = |col;
        end
    endgenerate

    // Decode of the current event
    wire native_mode = control_register_zero_native;
    wire scalar_unmasked = x87_exc_valid && |(x87_exc_flags & ~x87_exc_mask);
    wire pend_now = (state_reg == ST_PEND);
    // A save flagged without the no-wait bit still never takes the numeric trap
    wire fp_or_wait = insn_issue && (insn_is_wait || insn_is_fp) && !insn_is_nowait
        && !insn_is_nowait_save;
    wire unavail_hit = insn_issue && insn_is_fp && task_switched_flag;
    wire numeric_hit = fp_or_wait && pend_now && !unavail_hit;
    // Only new events count; old flags never fault on unmask
    wire simd_unmasked = simd_valid && |(simd_or & ~simd_mask);
    wire simd_masked_only = simd_valid && |simd_or && !simd_unmasked;
    wire save_pulse = insn_issue && insn_is_nowait_save && pend_now && !native_mode;
    assign sticky_next = simd_flag_clear ? (simd_valid ? simd_or : FLAGS_ZERO)
                       : (simd_sticky_flags | (simd_valid ? simd_or : FLAGS_ZERO));

    // Pending state; a new exception wins over the clear
    always_comb begin
        state_next = state_reg;
        pulse_cnt_next = pulse_cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (scalar_unmasked) begin
                    state_next = ST_PEND;
                end
            end
            ST_PEND: begin
                if (x87_status_clear && !scalar_unmasked) begin
                    state_next = ST_IDLE;
                end else if (save_pulse) begin
                    state_next = ST_PULSE;
                    pulse_cnt_next = SAVE_PULSE_CYC;
                end
            end
            ST_PULSE: begin
                // Save clears the unit, so the line drops after the pulse;
                // a fresh exception during the pulse is not lost
                pulse_cnt_next = pulse_cnt_reg - CNT_ONE;
                if (scalar_unmasked) begin
                    state_next = ST_PEND;
                end else if (pulse_cnt_reg == CNT_ONE) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            pulse_cnt_reg <= CNT_ZERO;
        end else if (clk_en) begin
            state_reg <= state_next;
            pulse_cnt_reg <= pulse_cnt_next;
        end
    end

    // Error line active in both modes, same program point
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            float_error_output_n <= 1'b1;
            scalar_pending <= 1'b0;
        end else if (clk_en) begin
            float_error_output_n <= (state_next == ST_IDLE);
            scalar_pending <= (state_next == ST_PEND);
        end
    end

    // Trap selection, internal and undelayed, registered once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trap_valid <= 1'b0;
            trap_vector <= VEC_NONE;
            insn_proceed <= 1'b0;
        end else if (clk_en) begin
            trap_valid <= unavail_hit || numeric_hit || simd_unmasked;
            insn_proceed <= insn_issue && !unavail_hit && !numeric_hit;
            if (unavail_hit) begin
                trap_vector <= VEC_UNAVAIL;
            end else if (numeric_hit) begin
                trap_vector <= VEC_NUMERIC;
            end else if (simd_unmasked) begin
                trap_vector <= VEC_SIMD;
            end else begin
                trap_vector <= VEC_NONE;
            end
        end
    end

    // SIMD sticky flags and default result; no external sign
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            simd_sticky_flags <= FLAGS_ZERO;
            simd_default_result <= 1'b0;
        end else if (clk_en) begin
            simd_sticky_flags <= sticky_next;
            simd_default_result <= simd_masked_only;
        end
    end

    // Checks
    a_pend_drives_err: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && scalar_unmasked |=> !float_error_output_n)
        else $error("error line not asserted after unmasked exception");
    a_numeric_trap: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && numeric_hit |=> trap_valid && trap_vector == VEC_NUMERIC)
        else $error("numeric trap missing");
    a_nowait_exempt: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && insn_issue && insn_is_nowait && !unavail_hit && !simd_unmasked
        |=> !trap_valid && insn_proceed)
        else $error("no-wait instruction trapped");
    a_nowait_keeps: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && pend_now && insn_issue && insn_is_nowait && !insn_is_nowait_save
        && !x87_status_clear |=> scalar_pending)
        else $error("pending lost on no-wait");
    a_native_err: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && native_mode && scalar_unmasked |=> !float_error_output_n)
        else $error("native mode error line missing");
    a_native_nosave: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && native_mode && insn_issue && insn_is_nowait_save
        |=> trap_vector != VEC_NUMERIC)
        else $error("no-wait save trapped in native mode");
    a_save_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && save_pulse && !x87_status_clear |=> state_reg == ST_PULSE)
        else $error("save pulse missing");
    a_masked_simd: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && simd_masked_only && !unavail_hit && !numeric_hit |=> !trap_valid
        && simd_default_result)
        else $error("masked SIMD exception misreported");
    a_simd_fault: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && simd_unmasked && !unavail_hit && !numeric_hit
        |=> trap_vector == VEC_SIMD)
        else $error("SIMD fault missing");
    a_unavail_first: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && unavail_hit |=> trap_vector == VEC_UNAVAIL)
        else $error("device-not-available not first");
    // Flags or masks alone never raise a trap
    a_flags_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !simd_valid && !numeric_hit && !unavail_hit |=> !trap_valid)
        else $error("trap without a new event");
    a_sticky_lane: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && simd_valid |=> (simd_sticky_flags & $past(simd_lane_flags[EXC_W-1:0]))
        == $past(simd_lane_flags[EXC_W-1:0]))
        else $error("lane flag missing from sticky set");
    a_save_line_low: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && save_pulse |=> !float_error_output_n)
        else $error("error line not pulsed on save");
    a_pend_holds: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && pend_now && !x87_status_clear && !save_pulse |=> scalar_pending)
        else $error("pending dropped without clear");

    c_numeric: cover property (@(posedge clk) disable iff (!reset_n) numeric_hit);
    c_save_pulse: cover property (@(posedge clk) disable iff (!reset_n) save_pulse);
    c_simd_fault: cover property (@(posedge clk) disable iff (!reset_n) simd_unmasked);
    c_unavail_over: cover property (@(posedge clk) disable iff (!reset_n)
        unavail_hit && pend_now);
    c_masked_simd: cover property (@(posedge clk) disable iff (!reset_n) simd_masked_only);
endmodule
`default_nettype wire

// ---- fpu_exc_pkg.sv ----
// Constants and types for the floating-point exception signalling block
`default_nettype none
package fpu_exc_pkg;
    localparam int EXC_W = 6;                       // Exception classes per unit
    localparam int LANES = 4;                       // Packed SIMD lanes
    localparam int NATIVE_SEL_BIT = 5;              // Native error select position
    localparam logic [7:0] VEC_NUMERIC = 8'h10;     // Trap 16
    localparam logic [7:0] VEC_SIMD = 8'h13;        // Fault 19
    localparam logic [7:0] VEC_UNAVAIL = 8'h07;     // Device not available
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam int SAVE_PULSE_NS = 20;              // Brief error pulse on no-wait save, outside native mode only
    localparam int CLK_NS = 10;
    localparam logic [3:0] SAVE_PULSE_CYC = 4'(SAVE_PULSE_NS / CLK_NS);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam logic [5:0] FLAGS_ZERO = 6'h00;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PEND = 3'b010,
        ST_PULSE = 3'b100
    } err_state_t;
endpackage
`default_nettype wire

// ---- intc_model.sv ----
// Interrupt controller model on the far side of the error line
`default_nettype none
module intc_model (
    input wire logic float_error_output_n,
    input wire logic legacy_request_enable,
    output logic maskable_interrupt_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // Legacy request gated by its enable; system keeps it off in native mode
    assign maskable_interrupt_input = legacy_request_enable & ~float_error_output_n;
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the exception signalling block
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
    $display("wrong value %s exp %0h got %0h", nm, ex, got); num_errors++; end end
module tb;
    import fpu_exc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic native = 1'b0;
    logic task_sw = 1'b0;
    logic ce = 1'b1;
    logic xv = 1'b0, xc = 1'b0, iss = 1'b0, ifp = 1'b0, iwt = 1'b0, inw = 1'b0, isv = 1'b0;
    logic sv = 1'b0, sc = 1'b0;
    logic [EXC_W-1:0] xf = FLAGS_ZERO, xmask = FLAGS_ZERO, sm = FLAGS_ZERO;
    logic [LANES*EXC_W-1:0] lf = '0;
    logic err_n, pend, tv, proceed, dflt, int_req;
    logic [7:0] vec;
    logic [EXC_W-1:0] sticky;
    int num_errors = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    fpu_exc_signal i_dut (.clk(clk), .reset_n(reset_n), .clk_en(ce),
        .control_register_zero_native(native), .task_switched_flag(task_sw),
        .x87_exc_valid(xv),
        .x87_exc_flags(xf), .x87_exc_mask(xmask), .x87_status_clear(xc), .insn_issue(iss),
        .insn_is_fp(ifp), .insn_is_wait(iwt), .insn_is_nowait(inw), .insn_is_nowait_save(isv),
        .simd_valid(sv), .simd_lane_flags(lf), .simd_mask(sm), .simd_flag_clear(sc),
        .float_error_output_n(err_n), .scalar_pending(pend), .trap_valid(tv),
        .trap_vector(vec), .insn_proceed(proceed), .simd_default_result(dflt),
        .simd_sticky_flags(sticky));
    intc_model i_intc (.float_error_output_n(err_n), .legacy_request_enable(~native),
        .maskable_interrupt_input(int_req));
    // One-cycle pulses; results are registered and settled at the next falling edge
    task automatic scalar_exc(input logic [EXC_W-1:0] f, input logic [EXC_W-1:0] m);
        xv = 1'b1; xf = f; xmask = m; @(negedge clk); xv = 1'b0;
    endtask
    task automatic insn(input logic fp, input logic wt, input logic nw, input logic s);
        iss = 1'b1; ifp = fp; iwt = wt; inw = nw; isv = s; @(negedge clk); iss = 1'b0;
    endtask
    task automatic simd(input logic [LANES*EXC_W-1:0] f, input logic [EXC_W-1:0] m);
        sv = 1'b1; lf = f; sm = m; @(negedge clk); sv = 1'b0;
    endtask
    task automatic clear_status();
        xc = 1'b1; @(negedge clk); xc = 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Watchdog; the whole sequence needs well under a microsecond
    initial begin
        #20000;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        `CHK("err_reset", 1'b1, err_n)
        scalar_exc(6'h01, 6'h01);
        `CHK("err_masked", 1'b1, err_n)
        scalar_exc(6'h04, 6'h00);
        `CHK("err_legacy", 1'b0, err_n)
        `CHK("pend", 1'b1, pend)
        `CHK("int_req_legacy", 1'b1, int_req)
        insn(1'b0, 1'b0, 1'b1, 1'b0);
        `CHK("nowait_trap", 1'b0, tv)
        `CHK("nowait_go", 1'b1, proceed)
        `CHK("nowait_pend", 1'b1, pend)
        insn(1'b1, 1'b0, 1'b0, 1'b0);
        `CHK("fp_trap", {1'b1, VEC_NUMERIC, 1'b0}, {tv, vec, proceed})
        insn(1'b0, 1'b1, 1'b0, 1'b0);
        `CHK("wait_trap", {1'b1, VEC_NUMERIC}, {tv, vec})
        `CHK("err_held", 1'b0, err_n)
        clear_status();
        `CHK("err_clear", 1'b1, err_n)
        native = 1'b1;
        scalar_exc(6'h08, 6'h00);
        `CHK("err_native", 1'b0, err_n)
        `CHK("int_req_native", 1'b0, int_req)
        insn(1'b0, 1'b0, 1'b1, 1'b1);
        `CHK("save_native", {1'b0, 1'b0}, {tv, err_n})
        insn(1'b0, 1'b1, 1'b0, 1'b0);
        `CHK("native_trap", {1'b1, VEC_NUMERIC}, {tv, vec})
        task_sw = 1'b1;
        insn(1'b1, 1'b0, 1'b0, 1'b0);
        `CHK("unavail_first", {1'b1, VEC_UNAVAIL, 1'b0}, {tv, vec, proceed})
        task_sw = 1'b0;
        clear_status();
        native = 1'b0;
        scalar_exc(6'h02, 6'h00);
        insn(1'b0, 1'b0, 1'b1, 1'b1);
        `CHK("save_pulse", {1'b0, 1'b0, 1'b0}, {err_n, pend, tv})
        repeat (2) @(negedge clk);
        `CHK("save_end", 1'b1, err_n)
        simd(24'h400001, 6'h3F);
        `CHK("simd_masked", {1'b1, 1'b0, 6'h11}, {dflt, tv, sticky})
        `CHK("simd_no_line", 1'b1, err_n)
        sm = 6'h00;
        @(negedge clk);
        `CHK("simd_late", 1'b0, tv)
        simd(24'h000400, 6'h00);
        `CHK("simd_fault", {1'b1, VEC_SIMD, 1'b0}, {tv, vec, dflt})
        sc = 1'b1;
        @(negedge clk);
        sc = 1'b0;
        `CHK("sticky_clr", FLAGS_ZERO, sticky)
        // Clock enable low: an unmasked exception must not be latched
        ce = 1'b0;
        scalar_exc(6'h01, 6'h00);
        `CHK("frozen", {1'b1, 1'b0}, {err_n, pend})
        ce = 1'b1;
        print_verdict();
    end
endmodule
`default_nettype wire
